// ---- design/modem_ctrl_regs.svh ----
// register offsets, field positions, reset values and timing counts of the
// modem control block; definitions only
`ifndef MODEM_CTRL_REGS_SVH
`define MODEM_CTRL_REGS_SVH
// word index of each register; byte address is four times the index
`define IDX_POWER_ENABLE 8'h37
`define IDX_TEST_BUS_SEL 8'h38
`define IDX_FILTER_PWR_OFF 8'h39
`define IDX_BURST_LEN_HIGH 8'h3a
`define IDX_LOOPBACK_OVL 8'h3b
`define IDX_TX_MODE 8'h40
`define IDX_BURST_LEN_LOW 8'h2e
`define IDX_STATUS 8'h3c
`define IDX_TX_TIMING 8'h3d
// field positions
`define BIT_TX_ENABLE 1
`define BIT_RX_ENABLE 2
`define BIT_BB_LOOP 0
`define BIT_IF_LOOP 1
`define OVL_LSB 2
`define BIT_TX_BPSK 0
// reset values
`define RST_CTRL 8'h00
`define RST_BURST 16'h0003
`define RST_CHIP_DIV 6'h01
`define RST_CHIPS_SYM 6'h0f
// receiver disable reset length in receive clock cycles
`define RX_RESET_CYCLES 3'd6
`endif

// ---- design/modem_ctrl_pkg.sv ----
// types shared by the modem control block
package modem_ctrl_pkg;
  typedef enum logic [2:0] {
    RX_OFF = 3'b001,
    RX_ACQ = 3'b010,
    RX_DATA = 3'b100
  } rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_PREAMBLE = 3'b010,
    TX_DATA = 3'b100
  } tx_state_t;
  typedef struct packed {
    logic [7:0] i;
    logic [7:0] q;
  } iq_sample_t;
endpackage

// ---- design/burst_modem_rx_tx_control.sv ----
// control register group of a spread spectrum burst modem, with rx enable
// handling, test bus mux, filter power saving, burst length, loopbacks,
// rx overlay generator and tx data request handshake.
// assumes one clock for bus, receive and transmit paths; pins are async.
// Operation
// - rx disable powers down; enable restarts acquisition
// - rx activity is register bit OR pin
// - disable starts six cycle datapath reset
// - datapath reset clears test bus select
// - four-bit select routes sixteen test points
// - seven power bits switch nine-tap sections
// - acquisition keeps all taps powered
// - tap zero powered whenever rx active
// - burst length sixteen bits, symbols equal value-1
// - exceeding burst count returns to acquisition
// - baseband loopback feeds tx baseband to filter
// - if loopback feeds tx if into rx i
// - overlay select decodes off, 63, 511, 1023
// - overlay removed one bit per symbol
// - overlay generator reset at burst start
// - tx mode bit: low qpsk, high bpsk
// - bpsk request one chip before symbol end
// - qpsk requests before mid and end
// - request drops after latching edge
// - requests repeat while transmit enable high
// - tx enable rise sends preamble then data
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`include "modem_ctrl_regs.svh"
module burst_modem_rx_tx_control
  import modem_ctrl_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // receive side
  input wire logic external_receive_enable_i,
  input wire logic acq_detect_i,
  input wire logic symbol_strobe_i,
  input wire logic rx_symbol_bit_i,
  input wire iq_sample_t rx_if_in_i,
  input wire iq_sample_t mf_in_i,
  input wire logic [7:0] test_point_i [16],
  output iq_sample_t mf_feed_o,
  output logic [7:0] rx_i_sample_in_o,
  output logic [7:0] receive_test_bus_o,
  output logic [63:0] tap_power_o,
  output logic rx_active_o,
  output logic rx_datapath_reset_o,
  output logic rx_acquisition_o,
  output logic rx_data_bit_o,
  // transmit side
  input wire logic external_transmit_enable_i,
  input wire logic tx_i_baseband_i,
  input wire logic tx_q_baseband_i,
  input wire logic [7:0] tx_if_sample_out_i,
  input wire logic tx_serial_data_in_i,
  output logic tx_data_request_o,
  output logic tx_bit_o,
  output logic tx_bit_valid_o,
  output logic tx_bpsk_o,
  output logic tx_preamble_o
);
  localparam logic [ADDR_W-1:0] A_PWR = ADDR_W'({`IDX_POWER_ENABLE, 2'b00});
  localparam logic [ADDR_W-1:0] A_TSEL = ADDR_W'({`IDX_TEST_BUS_SEL, 2'b00});
  localparam logic [ADDR_W-1:0] A_FPO = ADDR_W'({`IDX_FILTER_PWR_OFF, 2'b00});
  localparam logic [ADDR_W-1:0] A_BLH = ADDR_W'({`IDX_BURST_LEN_HIGH, 2'b00});
  localparam logic [ADDR_W-1:0] A_BLL = ADDR_W'({`IDX_BURST_LEN_LOW, 2'b00});
  localparam logic [ADDR_W-1:0] A_LOV = ADDR_W'({`IDX_LOOPBACK_OVL, 2'b00});
  localparam logic [ADDR_W-1:0] A_TXM = ADDR_W'({`IDX_TX_MODE, 2'b00});
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'({`IDX_STATUS, 2'b00});
  localparam logic [ADDR_W-1:0] A_TTIM = ADDR_W'({`IDX_TX_TIMING, 2'b00});

  // overlay lfsr step for the selected length
  function automatic logic [9:0] ovl_step(input logic [1:0] sel, input logic [9:0] s);
    logic fb;
    fb = 1'b0;
    case (sel)
      2'd1: fb = s[5] ^ s[4] ^ s[2] ^ s[1];
      2'd2: fb = s[8] ^ s[4] ^ s[2] ^ s[1];
      2'd3: fb = s[9] ^ s[4] ^ s[2] ^ s[1];
      default: fb = 1'b0;
    endcase
    return {s[8:0], fb};
  endfunction

  // pin synchronisers
  logic rxen_s1_reg, rxen_s2_reg, txen_s1_reg, txen_s2_reg, txd_s1_reg, txd_s2_reg;
  always_ff @(posedge clk_i) begin
    rxen_s1_reg <= external_receive_enable_i;
    rxen_s2_reg <= rxen_s1_reg;
    txen_s1_reg <= external_transmit_enable_i;
    txen_s2_reg <= txen_s1_reg;
    txd_s1_reg <= tx_serial_data_in_i;
    txd_s2_reg <= txd_s1_reg;
  end

  // registers
  logic [7:0] pwr_reg, tsel_reg, fpo_reg, blh_reg, bll_reg, lov_reg, txm_reg;
  logic [5:0] chip_div_reg, chips_sym_reg;
  logic [2:0] rst_cnt_reg;
  logic rx_eff, rx_eff_d_reg;
  logic wr, rd_hit;
  assign wr = cyc_i & stb_i & we_i & ~ack_o;
  assign rx_eff = pwr_reg[`BIT_RX_ENABLE] | rxen_s2_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg <= `RST_CTRL;
      fpo_reg <= `RST_CTRL;
      blh_reg <= 8'(`RST_BURST >> 8);
      bll_reg <= 8'(`RST_BURST);
      lov_reg <= `RST_CTRL;
      txm_reg <= `RST_CTRL;
      chip_div_reg <= `RST_CHIP_DIV;
      chips_sym_reg <= `RST_CHIPS_SYM;
    end else if (wr && sel_i[0]) begin
      case (adr_i)
        A_PWR: pwr_reg <= dat_i[7:0];
        A_FPO: fpo_reg <= dat_i[7:0];
        A_BLH: blh_reg <= dat_i[7:0];
        A_BLL: bll_reg <= dat_i[7:0];
        A_LOV: lov_reg <= dat_i[7:0];
        A_TXM: txm_reg <= dat_i[7:0];
        A_TTIM: begin
          chip_div_reg <= dat_i[5:0];
          if (sel_i[1]) begin
            chips_sym_reg <= dat_i[13:8];
          end
        end
        default: ;
      endcase
    end
  end

  // test select, cleared by the receiver disable reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsel_reg <= `RST_CTRL;
    end else if (rst_cnt_reg != 3'd0) begin
      tsel_reg <= `RST_CTRL;
    end else if (wr && sel_i[0] && adr_i == A_TSEL) begin
      tsel_reg <= dat_i[7:0];
    end
  end

  // six cycle datapath reset on the fall of effective enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_eff_d_reg <= 1'b0;
      rst_cnt_reg <= 3'd0;
    end else begin
      rx_eff_d_reg <= rx_eff;
      if (rx_eff_d_reg && !rx_eff) begin
        rst_cnt_reg <= `RX_RESET_CYCLES;
      end else if (rst_cnt_reg != 3'd0) begin
        rst_cnt_reg <= rst_cnt_reg - 3'd1;
      end
    end
  end

  // receiver state: off, acquisition, data symbols
  rx_state_t rx_state_reg;
  logic [15:0] sym_cnt_reg;
  logic [15:0] burst_len;
  logic [9:0] ovl_reg;
  logic [1:0] ovl_sel;
  assign burst_len = {blh_reg, bll_reg};
  assign ovl_sel = lov_reg[`OVL_LSB +: 2];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= RX_OFF;
      sym_cnt_reg <= 16'h0000;
      ovl_reg <= 10'h3ff;
    end else begin
      case (rx_state_reg)
        RX_OFF: if (rx_eff && rst_cnt_reg == 3'd0) rx_state_reg <= RX_ACQ;
        RX_ACQ: begin
          sym_cnt_reg <= 16'h0000;
          ovl_reg <= 10'h3ff;
          if (acq_detect_i) rx_state_reg <= RX_DATA;
        end
        RX_DATA: begin
          if (symbol_strobe_i) begin
            sym_cnt_reg <= sym_cnt_reg + 16'h0001;
            ovl_reg <= ovl_step(ovl_sel, ovl_reg);
            if (sym_cnt_reg + 16'h0001 > burst_len - 16'h0002) begin
              rx_state_reg <= RX_ACQ;
            end
          end
        end
        default: rx_state_reg <= RX_OFF;
      endcase
      if (!rx_eff) rx_state_reg <= RX_OFF;
    end
  end

  // receive outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_active_o <= 1'b0;
      rx_datapath_reset_o <= 1'b0;
      rx_acquisition_o <= 1'b0;
      rx_data_bit_o <= 1'b0;
      tap_power_o <= 64'h0000_0000_0000_0000;
      receive_test_bus_o <= 8'h00;
      mf_feed_o <= '0;
      rx_i_sample_in_o <= 8'h00;
    end else begin
      rx_active_o <= rx_eff;
      rx_datapath_reset_o <= (rx_eff_d_reg && !rx_eff) || rst_cnt_reg > 3'd1;
      rx_acquisition_o <= rx_state_reg == RX_ACQ;
      rx_data_bit_o <= rx_symbol_bit_i ^ ((ovl_sel != 2'd0) & ovl_reg[0]);
      tap_power_o[0] <= rx_eff;
      for (int k = 0; k < 7; k++) begin
        tap_power_o[1 + 9 * k +: 9] <= {9{rx_eff & (rx_state_reg != RX_DATA
                                          | !fpo_reg[k])}};
      end
      receive_test_bus_o <= test_point_i[tsel_reg[3:0]];
      if (lov_reg[`BIT_BB_LOOP]) begin
        mf_feed_o.i <= {8{tx_i_baseband_i}};
        mf_feed_o.q <= {8{tx_q_baseband_i}};
      end else begin
        mf_feed_o <= mf_in_i;
      end
      rx_i_sample_in_o <= lov_reg[`BIT_IF_LOOP] ? tx_if_sample_out_i
                                              : rx_if_in_i.i;
    end
  end

  // transmit chip and symbol timing with data request
  tx_state_t tx_state_reg;
  logic tx_on, tx_on_d_reg, chip_tick;
  logic [5:0] div_cnt_reg, chip_cnt_reg;
  logic bpsk, req_point, latch_point;
  logic [6:0] half_sym;
  assign tx_on = pwr_reg[`BIT_TX_ENABLE] | txen_s2_reg;
  assign bpsk = txm_reg[`BIT_TX_BPSK];
  assign chip_tick = div_cnt_reg == 6'd0;
  // chips in the first half of a symbol; mid request sits one chip before
  assign half_sym = ({1'b0, chips_sym_reg} + 7'd1) >> 1;
  // chip_cnt counts down through chips_sym..0; last chip is 0
  assign req_point = chip_tick && tx_state_reg != TX_IDLE && tx_state_reg != TX_PREAMBLE
                     && (chip_cnt_reg == 6'd1
                         || (!bpsk && chip_cnt_reg == half_sym[5:0] + 6'd1));
  assign latch_point = chip_tick && tx_data_request_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_reg <= TX_IDLE;
      tx_on_d_reg <= 1'b0;
      div_cnt_reg <= 6'd0;
      chip_cnt_reg <= 6'd0;
    end else begin
      tx_on_d_reg <= tx_on;
      div_cnt_reg <= chip_tick ? chip_div_reg : div_cnt_reg - 6'd1;
      case (tx_state_reg)
        TX_IDLE: if (tx_on && !tx_on_d_reg) begin
          tx_state_reg <= TX_PREAMBLE;
          chip_cnt_reg <= chips_sym_reg;
        end
        TX_PREAMBLE, TX_DATA: if (chip_tick) begin
          if (chip_cnt_reg == 6'd0) begin
            chip_cnt_reg <= chips_sym_reg;
            tx_state_reg <= TX_DATA;
          end else begin
            chip_cnt_reg <= chip_cnt_reg - 6'd1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
      if (!tx_on) tx_state_reg <= TX_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_request_o <= 1'b0;
      tx_bit_o <= 1'b0;
      tx_bit_valid_o <= 1'b0;
      tx_bpsk_o <= 1'b0;
      tx_preamble_o <= 1'b0;
    end else begin
      tx_bit_valid_o <= latch_point;
      if (latch_point) begin
        tx_data_request_o <= 1'b0;
        tx_bit_o <= txd_s2_reg;
      end else if (req_point) begin
        tx_data_request_o <= 1'b1;
      end else if (tx_state_reg == TX_IDLE) begin
        tx_data_request_o <= 1'b0;
      end
      tx_bpsk_o <= bpsk;
      tx_preamble_o <= tx_state_reg == TX_PREAMBLE;
    end
  end

  // status byte for software
  logic [7:0] status;
  assign status[0] = rx_eff;
  assign status[1] = rx_state_reg == RX_ACQ;
  assign status[2] = rx_state_reg == RX_DATA;
  assign status[3] = rst_cnt_reg != 3'd0;
  assign status[4] = tx_state_reg == TX_DATA;
  assign status[5] = tx_state_reg == TX_PREAMBLE;
  assign status[7:6] = 2'b00;

  // wishbone answer, one wait state
  always_comb begin
    rd_hit = 1'b1;
    case (adr_i)
      A_PWR, A_TSEL, A_FPO, A_BLH, A_BLL, A_LOV, A_TXM, A_STAT, A_TTIM: rd_hit = 1'b1;
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0000_0000;
      if (cyc_i && stb_i && !we_i && rd_hit) begin
        case (adr_i)
          A_PWR: dat_o[7:0] <= pwr_reg;
          A_TSEL: dat_o[7:0] <= tsel_reg;
          A_FPO: dat_o[7:0] <= fpo_reg;
          A_BLH: dat_o[7:0] <= blh_reg;
          A_BLL: dat_o[7:0] <= bll_reg;
          A_LOV: dat_o[7:0] <= lov_reg;
          A_TXM: dat_o[7:0] <= txm_reg;
          A_STAT: dat_o[7:0] <= status;
          A_TTIM: dat_o[15:0] <= {2'b00, chips_sym_reg, 2'b00, chip_div_reg};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // burst_modem_rx_tx_control

// ---- verif/burst_modem_rx_tx_control_properties.sv ----
// checker of rx reset, tap power and tx request timing
// bound to the control block; sees its ports only
`timescale 1ns/10ps
module modem_ctrl_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched outputs
  input wire logic ack_o,
  input wire logic rx_active_o,
  input wire logic rx_datapath_reset_o,
  input wire logic rx_acquisition_o,
  input wire logic [63:0] tap_power_o,
  input wire logic tx_data_request_o,
  input wire logic tx_bit_valid_o,
  input wire logic tx_preamble_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_rx_reset_six: assert property (
    $fell(rx_active_o) |-> ##[0:1] $rose(rx_datapath_reset_o) ##0
    rx_datapath_reset_o [*6] ##1 !rx_datapath_reset_o)
    else $error("datapath reset not six cycles");
  a_rx_wake_acq: assert property ($rose(rx_active_o) |-> ##[0:3] rx_acquisition_o)
    else $error("no acquisition after enable");
  a_acq_taps_on: assert property (
    rx_acquisition_o && $past(rx_acquisition_o) && rx_active_o |-> &tap_power_o)
    else $error("tap off in acquisition");
  a_tap_zero_on: assert property (
    rx_active_o && $past(rx_active_o) |-> tap_power_o[0])
    else $error("tap zero off");
  a_req_then_latch: assert property (
    $rose(tx_data_request_o) |-> !tx_bit_valid_o ##[1:10] tx_bit_valid_o)
    else $error("no latch after request");
  a_req_drop: assert property (tx_bit_valid_o |-> ##[0:1] !tx_data_request_o)
    else $error("request held past latch");
  a_preamble_quiet: assert property (tx_preamble_o |-> !tx_bit_valid_o)
    else $error("latch during preamble");
  cover property ($fell(rx_active_o));
  cover property ($fell(rx_acquisition_o));
  cover property (tx_bit_valid_o && !tx_preamble_o);
endmodule // modem_ctrl_props

// ---- verif/tx_source_model.sv ----
// serial data source on the far side of the tx request handshake
// same clock as the block; slow_i delays each answer by one cycle
`timescale 1ns/10ps
module tx_source_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // handshake
  input wire logic slow_i,
  input wire logic tx_data_request_i,
  output logic tx_serial_data_in_o,
  output logic load_o
);
  logic req_reg;
  logic pend_reg;
  logic [7:0] lfsr_reg;
  always_ff @(posedge clk_i) begin
    req_reg <= tx_data_request_i;
    load_o <= 1'b0;
    if (rst_i) begin
      pend_reg <= 1'b0;
      lfsr_reg <= 8'h1d;
      tx_serial_data_in_o <= 1'b0;
    end else if (tx_data_request_i && !req_reg && slow_i) begin
      pend_reg <= 1'b1;
    end else if ((tx_data_request_i && !req_reg) || pend_reg) begin
      pend_reg <= 1'b0;
      tx_serial_data_in_o <= lfsr_reg[0];
      lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[2] ^ lfsr_reg[3] ^ lfsr_reg[4], lfsr_reg[7:1]};
      load_o <= 1'b1;
    end else if (!tx_data_request_i && req_reg) begin
      tx_serial_data_in_o <= ~tx_serial_data_in_o; // invert, line no longer valid
    end
  end
endmodule // tx_source_model

// ---- verif/burst_modem_rx_tx_control_tb.sv ----
// self-checking bench of the modem control block
// drives wishbone and pins on rising edges; tx source model answers requests
`timescale 1ns/10ps
`include "modem_ctrl_regs.svh"
module burst_modem_rx_tx_control_tb
  import modem_ctrl_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0000_0000;
  logic external_receive_enable_i = 1'b0, acq_detect_i = 1'b0, symbol_strobe_i = 1'b0;
  logic rx_symbol_bit_i = 1'b0, external_transmit_enable_i = 1'b0, slow = 1'b0;
  logic tx_i_baseband_i = 1'b1, tx_q_baseband_i = 1'b0, load;
  logic [7:0] tx_if_sample_out_i = 8'h00;
  logic [7:0] test_point_i [16];
  iq_sample_t rx_if_in_i, mf_in_i, mf_feed_o;
  logic [31:0] dat_o;
  logic ack_o, rx_active_o, rx_datapath_reset_o, rx_acquisition_o, rx_data_bit_o;
  logic tx_serial_data_in_i, tx_data_request_o, tx_bit_o, tx_bit_valid_o;
  logic tx_bpsk_o, tx_preamble_o;
  logic [7:0] rx_i_sample_in_o, receive_test_bus_o;
  logic [63:0] tap_power_o;
  logic [31:0] seed = 32'h0000_0014;
  logic [31:0] rd_q [$];
  logic tx_q [$];
  int bad_count = 0;
  int check_count = 0;
  logic [7:0] ri [6] = '{8'h37, 8'h38, 8'h3a, 8'h2e, 8'h3d, 8'h3e};
  logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0003, 32'h0000_0f01, 32'h0000_0000};
  always #4 clk_i = ~clk_i;
  burst_modem_rx_tx_control u_burst_modem_rx_tx_control (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .external_receive_enable_i, .acq_detect_i, .symbol_strobe_i, .rx_symbol_bit_i,
    .rx_if_in_i, .mf_in_i, .test_point_i, .mf_feed_o, .rx_i_sample_in_o,
    .receive_test_bus_o, .tap_power_o, .rx_active_o, .rx_datapath_reset_o,
    .rx_acquisition_o, .rx_data_bit_o, .external_transmit_enable_i, .tx_i_baseband_i,
    .tx_q_baseband_i, .tx_if_sample_out_i, .tx_serial_data_in_i, .tx_data_request_o,
    .tx_bit_o, .tx_bit_valid_o, .tx_bpsk_o, .tx_preamble_o
  );
  tx_source_model u_tx_source_model (.clk_i, .rst_i, .slow_i(slow),
    .tx_data_request_i(tx_data_request_o), .tx_serial_data_in_o(tx_serial_data_in_i),
    .load_o(load));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [63:0] taps(input logic [6:0] off);
    logic [63:0] t;
    t[0] = 1'b1;
    for (int n = 1; n < 64; n++) t[n] = !off[(n - 1) / 9];
    return t;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    if (!w) rd_q.push_back(d);
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input logic acq, input logic b);
    rx_symbol_bit_i <= b;
    acq_detect_i <= acq;
    symbol_strobe_i <= !acq;
    @(posedge clk_i);
    acq_detect_i <= 1'b0;
    symbol_strobe_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    @(posedge clk_i);
    while (tx_bit_valid_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 200) begin
      bad_count++;
      finish_test();
    end
  endtask
  always @(posedge clk_i) begin
    if (load === 1'b1) tx_q.push_back(tx_serial_data_in_i);
    if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0) chk(dat_o, rd_q.pop_front());
    if (tx_bit_valid_o === 1'b1 && tx_q.size() > 0) chk(tx_bit_o, tx_q.pop_front());
  end
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    logic [7:0] b;
    int n;
    for (int k = 0; k < 16; k++) test_point_i[k] <= rnd();
    rx_if_in_i <= {rnd(), rnd()};
    mf_in_i <= {rnd(), rnd()};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int k = 0; k < 6; k++) wb(1'b0, ri[k], rv[k]);
    wb(1'b1, `IDX_POWER_ENABLE, 32'h0000_0004);
    for (int s = 0; s < 16; s++) begin
      wb(1'b1, `IDX_TEST_BUS_SEL, s);
      chk(receive_test_bus_o, test_point_i[s]);
    end
    wb(1'b1, `IDX_FILTER_PWR_OFF, 32'h0000_0055);
    wb(1'b1, `IDX_BURST_LEN_LOW, 32'h0000_0004);
    chk(rx_acquisition_o, 1'b1);
    chk(tap_power_o, {64{1'b1}});
    pulse(1'b1, 1'b0);
    @(posedge clk_i);
    chk(tap_power_o, taps(7'h55));
    pulse(1'b0, 1'b0);
    chk(rx_acquisition_o, 1'b0);
    pulse(1'b0, 1'b0);
    pulse(1'b0, 1'b0);
    @(posedge clk_i);
    chk(rx_acquisition_o, 1'b1);
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, `IDX_LOOPBACK_OVL, (k % 4) << 2);
      pulse(1'b1, 1'b0);
      b = rnd();
      pulse(1'b0, b[0]);
      chk(rx_data_bit_o, b[0] ^ (k % 4 != 0));
      pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b1);
    end
    tx_if_sample_out_i <= rnd();
    wb(1'b1, `IDX_LOOPBACK_OVL, 32'h0000_0003);
    chk(mf_feed_o, 16'hff00);
    chk(rx_i_sample_in_o, tx_if_sample_out_i);
    wb(1'b1, `IDX_LOOPBACK_OVL, 32'h0000_0000);
    chk(mf_feed_o, mf_in_i);
    chk(rx_i_sample_in_o, rx_if_in_i.i);
    external_receive_enable_i <= 1'b1;
    pulse(1'b1, 1'b0);
    wb(1'b1, `IDX_POWER_ENABLE, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    chk(rx_active_o, 1'b1);
    external_receive_enable_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk(rx_active_o, 1'b0);
    wb(1'b0, `IDX_TEST_BUS_SEL, 32'h0000_0000);
    wb(1'b0, `IDX_FILTER_PWR_OFF, 32'h0000_0055);
    wb(1'b1, `IDX_POWER_ENABLE, 32'h0000_0004);
    @(posedge clk_i);
    chk(rx_acquisition_o, 1'b1);
    wb(1'b0, `IDX_STATUS, 32'h0000_0003);
    wb(1'b1, `IDX_TEST_BUS_SEL, 32'h0000_0005);
    chk(receive_test_bus_o, test_point_i[5]);
    wb(1'b1, `IDX_TX_TIMING, 32'h0000_0307);
    for (int m = 1; m >= 0; m--) begin
      wb(1'b1, `IDX_TX_MODE, m);
      chk(tx_bpsk_o, m[0]);
      slow <= !m[0];
      tx_q.delete();
      external_transmit_enable_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(tx_preamble_o, 1'b1);
      wait_valid(n);
      for (int j = 0; j < 3; j++) begin
        wait_valid(n);
        chk(n + 1, m ? 32 : 16);
      end
      external_transmit_enable_i <= 1'b0;
      repeat (64) @(posedge clk_i);
    end
    finish_test();
  end
endmodule // burst_modem_rx_tx_control_tb
bind burst_modem_rx_tx_control modem_ctrl_props u_modem_ctrl_props (.clk_i(clk_i),
  .rst_i(rst_i), .ack_o(ack_o), .rx_active_o(rx_active_o),
  .rx_datapath_reset_o(rx_datapath_reset_o), .rx_acquisition_o(rx_acquisition_o),
  .tap_power_o(tap_power_o), .tx_data_request_o(tx_data_request_o),
  .tx_bit_valid_o(tx_bit_valid_o), .tx_preamble_o(tx_preamble_o));
